// File: hw/hpfs_pkg.sv
/*
 * Shared constants for the host port pin function select: control word layout,
 * reset values, pin roles and the host end's register map.
 * Assumes nothing of its surroundings.
 */
package hpfs_pkg;

	localparam int NPIN = 4;

	// Device control word layout
	localparam int CTRL_W       = 20;
	localparam int CB_HI_EN     = 0;
	localparam int CB_MUX       = 1;
	localparam int CB_DBL       = 2;
	localparam int CB_DS_POL    = 3;
	localparam int CB_CS_POL    = 4;
	localparam int CB_GMODE_LO  = 8;
	localparam int CB_GOUT_LO   = 16;

	// Reset: GPIO, all pins disconnected, strobes and select active low
	localparam logic [CTRL_W-1:0] CTRL_RST = 20'h00000;

	// Per-pin GPIO mode
	typedef enum logic [1:0] {
		HPFS_G_DISC  = 2'b00,
		HPFS_G_IN    = 2'b01,
		HPFS_G_OUT   = 2'b10,
		HPFS_G_DISC2 = 2'b11
	} hpfs_gmode_t;

	// Per-pin function as reported
	typedef enum logic [1:0] {
		HPFS_F_DISC = 2'b00,
		HPFS_F_GIN  = 2'b01,
		HPFS_F_GOUT = 2'b10,
		HPFS_F_HOST = 2'b11
	} hpfs_func_t;

	// Shared pin indices
	localparam int PIN_A  = 0;
	localparam int PIN_RW = 1;
	localparam int PIN_DS = 2;
	localparam int PIN_CS = 3;

	// Level of an undriven pin
	localparam logic PULL_LVL = 1'b1;

	// Host end register map (AXI4-Lite byte addresses)
	localparam logic [3:0]  REG_CTRL  = 4'h0;
	localparam logic [3:0]  REG_DRIVE = 4'h4;
	localparam logic [3:0]  REG_SENSE = 4'h8;
	localparam int HB_MUX     = 0;
	localparam int HB_DBL     = 1;
	localparam int HB_DS_POL  = 2;
	localparam int HB_CS_POL  = 3;
	localparam int HB_OE_LO   = 8;
	localparam logic [31:0] HCTRL_MASK = 32'h00000F0F;
	localparam logic [31:0] DRIVE_MASK = 32'h0000000F;
	localparam logic [1:0]  RESP_OKAY  = 2'b00;
	localparam logic [1:0]  RESP_SLV   = 2'b10;

endpackage : hpfs_pkg

// File: hw/hpfs_if.sv
/*
 * Four shared host port pins between the device end and the host end.
 * Assumes the bench joins both modports; an undriven pin reads high.
 */
`timescale 1ns/1ps
interface hpfs_if;
	logic [hpfs_pkg::NPIN-1:0] dev_o;
	logic [hpfs_pkg::NPIN-1:0] dev_oe;
	logic [hpfs_pkg::NPIN-1:0] host_o;
	logic [hpfs_pkg::NPIN-1:0] host_oe;
	logic [hpfs_pkg::NPIN-1:0] pin_lvl;

	// Device drive wins a contention so the wire stays defined
	genvar i;
	for (i = 0; i < hpfs_pkg::NPIN; i++) begin : g_pin
		assign pin_lvl[i] = dev_oe[i] ? dev_o[i] : (host_oe[i] ? host_o[i] : hpfs_pkg::PULL_LVL);
	end

	modport dev  (input pin_lvl, output dev_o, output dev_oe);
	modport host (input pin_lvl, output host_o, output host_oe);
endinterface : hpfs_if

// File: hw/hpfs_dev.sv
/*
 * Device end: selects the role of four shared host port pins from the
 * host port control word, qualifies strobes and drives GPIO outputs.
 * Assumes pins are asynchronous to aclk and the host keeps its own timing.
 */
`timescale 1ns/1ps
module hpfs_dev (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	hpfs_if.dev                                pins,
	input  wire logic                          cfg_we,
	input  wire logic [hpfs_pkg::CTRL_W-1:0]   cfg_wdata,
	output logic      [hpfs_pkg::CTRL_W-1:0]   cfg_rdata,
	output logic      [2*hpfs_pkg::NPIN-1:0]   pin_func,
	output logic      [hpfs_pkg::NPIN-1:0]     gpio_in,
	output logic                               host_addr_bit_two,
	output logic                               host_addr_bit_nine,
	output logic                               host_addr_bit_ten,
	output logic                               host_read_write_select,
	output logic                               host_read_strobe,
	output logic                               host_single_strobe,
	output logic                               host_write_strobe,
	output logic                               host_chip_select_in
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Polarity bit low means the pin is active low
	function automatic logic qual(input logic lvl, input logic pol);
		qual = pol ? lvl : ~lvl;
	endfunction : qual

	function automatic logic [1:0] gmode(input logic [hpfs_pkg::CTRL_W-1:0] c, input int i);
		gmode = c[hpfs_pkg::CB_GMODE_LO + 2*i +: 2];
	endfunction : gmode

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [hpfs_pkg::CTRL_W-1:0]   host_port_control_reg_r;
	logic [hpfs_pkg::NPIN-1:0]     sync1_r;
	logic [hpfs_pkg::NPIN-1:0]     sync2_r;
	logic [hpfs_pkg::NPIN-1:0]     dev_o_r;
	logic [hpfs_pkg::NPIN-1:0]     dev_oe_r;
	logic [hpfs_pkg::NPIN-1:0]     dev_o_nxt;
	logic [hpfs_pkg::NPIN-1:0]     dev_oe_nxt;
	logic [hpfs_pkg::NPIN-1:0]     gpio_in_r;
	logic [hpfs_pkg::NPIN-1:0]     gpio_in_nxt;
	logic [2*hpfs_pkg::NPIN-1:0]   pin_func_r;
	logic [2*hpfs_pkg::NPIN-1:0]   pin_func_nxt;
	logic                          a2_r;
	logic                          a9_r;
	logic                          a10_r;
	logic                          rw_r;
	logic                          rd_r;
	logic                          ds_r;
	logic                          wr_r;
	logic                          cs_r;
	wire                           hi_en;
	wire                           mux;
	wire                           dbl;
	wire                           ds_pol;
	wire                           cs_pol;
	wire                           hi_nonmux;
	wire                           hi_mux;
	wire                           hi_single;
	wire                           hi_double;
	wire  [hpfs_pkg::NPIN-1:0]     gout;

	////////////////////////////////////////////////////////////////////////////////
	// Control word decode

	assign hi_en     = host_port_control_reg_r[hpfs_pkg::CB_HI_EN];
	assign mux       = host_port_control_reg_r[hpfs_pkg::CB_MUX];
	assign dbl       = host_port_control_reg_r[hpfs_pkg::CB_DBL];
	assign ds_pol    = host_port_control_reg_r[hpfs_pkg::CB_DS_POL];
	assign cs_pol    = host_port_control_reg_r[hpfs_pkg::CB_CS_POL];
	assign gout      = host_port_control_reg_r[hpfs_pkg::CB_GOUT_LO +: hpfs_pkg::NPIN];
	assign hi_nonmux = hi_en & ~mux;
	assign hi_mux    = hi_en & mux;
	assign hi_single = hi_en & ~dbl;
	assign hi_double = hi_en & dbl;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_port_control_reg_r <= hpfs_pkg::CTRL_RST;
		end else if (cfg_we) begin
			host_port_control_reg_r <= cfg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser; only the second stage is read

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pins.pin_lvl;
			sync2_r <= sync1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// GPIO drive, sampling and pin role report

	// Host function makes every shared pin an input; reserved mode code 11 disconnects
	always_comb begin
		dev_o_nxt    = '0;
		dev_oe_nxt   = '0;
		gpio_in_nxt  = '0;
		pin_func_nxt = '0;
		for (int i = 0; i < hpfs_pkg::NPIN; i++) begin
			if (hi_en) begin
				pin_func_nxt[2*i +: 2] = hpfs_pkg::HPFS_F_HOST;
			end else begin
				case (gmode(host_port_control_reg_r, i))
					hpfs_pkg::HPFS_G_IN: begin
						gpio_in_nxt[i]          = sync2_r[i];
						pin_func_nxt[2*i +: 2]  = hpfs_pkg::HPFS_F_GIN;
					end
					hpfs_pkg::HPFS_G_OUT: begin
						dev_o_nxt[i]            = gout[i];
						dev_oe_nxt[i]           = 1'b1;
						pin_func_nxt[2*i +: 2]  = hpfs_pkg::HPFS_F_GOUT;
					end
					default: begin
						pin_func_nxt[2*i +: 2]  = hpfs_pkg::HPFS_F_DISC;
					end
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dev_o_r    <= '0;
			dev_oe_r   <= '0;
			gpio_in_r  <= '0;
			pin_func_r <= '0;
		end else begin
			dev_o_r    <= dev_o_nxt;
			dev_oe_r   <= dev_oe_nxt;
			gpio_in_r  <= gpio_in_nxt;
			pin_func_r <= pin_func_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host bus functions; unselected ones read zero

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a2_r  <= 1'b0;
			a9_r  <= 1'b0;
			a10_r <= 1'b0;
			rw_r  <= 1'b0;
			rd_r  <= 1'b0;
			ds_r  <= 1'b0;
			wr_r  <= 1'b0;
			cs_r  <= 1'b0;
		end else begin
			a2_r  <= hi_nonmux & sync2_r[hpfs_pkg::PIN_A];
			a9_r  <= hi_mux & sync2_r[hpfs_pkg::PIN_A];
			a10_r <= hi_mux & sync2_r[hpfs_pkg::PIN_CS];
			rw_r  <= hi_single & sync2_r[hpfs_pkg::PIN_RW];
			rd_r  <= hi_double & qual(sync2_r[hpfs_pkg::PIN_RW], ds_pol);
			ds_r  <= hi_single & qual(sync2_r[hpfs_pkg::PIN_DS], ds_pol);
			wr_r  <= hi_double & qual(sync2_r[hpfs_pkg::PIN_DS], ds_pol);
			cs_r  <= hi_nonmux & qual(sync2_r[hpfs_pkg::PIN_CS], cs_pol);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign pins.dev_o             = dev_o_r;
	assign pins.dev_oe            = dev_oe_r;
	assign cfg_rdata              = host_port_control_reg_r;
	assign pin_func               = pin_func_r;
	assign gpio_in                = gpio_in_r;
	assign host_addr_bit_two      = a2_r;
	assign host_addr_bit_nine     = a9_r;
	assign host_addr_bit_ten      = a10_r;
	assign host_read_write_select = rw_r;
	assign host_read_strobe       = rd_r;
	assign host_single_strobe     = ds_r;
	assign host_write_strobe      = wr_r;
	assign host_chip_select_in    = cs_r;

endmodule : hpfs_dev

// File: hw/hpfs_host.sv
/*
 * Host end: drives the four shared pins as the external host bus would,
 * under AXI4-Lite control registers, and reports the pin levels.
 * Assumes one AXI4-Lite master on aclk and pins asynchronous to aclk.
 */
`timescale 1ns/1ps
module hpfs_host (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	hpfs_if.host               pins,
	input  wire logic [3:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [3:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready
);

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				o[8*b +: 8] = n[8*b +: 8];
			end
		end
		merge = o;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////

	logic [31:0] ctrl_r, drive_r, wdata_r, rdata_r;
	logic [3:0]  awaddr_r, wstrb_r, sync1_r, sync2_r, host_o_r, host_oe_r;
	logic [1:0]  bresp_r, rresp_r;
	logic        aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	wire         aw_hs, w_hs, ar_hs, do_wr, aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;
	wire         wr_ctrl, wr_drive, rd_ok;
	wire  [31:0] rd_val;
	wire         mux, dbl, ds_pol, cs_pol;
	wire  [3:0]  pin_nxt;

	assign aw_hs      = s_axi_awvalid & awready_r;
	assign w_hs       = s_axi_wvalid & wready_r;
	assign ar_hs      = s_axi_arvalid & arready_r;
	assign do_wr      = aw_got_r & w_got_r & ~bvalid_r;
	assign aw_got_nxt = (aw_got_r | aw_hs) & ~do_wr;
	assign w_got_nxt  = (w_got_r | w_hs) & ~do_wr;
	assign bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready);
	assign rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_rready);
	assign wr_ctrl    = do_wr & (awaddr_r == hpfs_pkg::REG_CTRL);
	assign wr_drive   = do_wr & (awaddr_r == hpfs_pkg::REG_DRIVE);
	assign rd_ok      = (s_axi_araddr == hpfs_pkg::REG_CTRL) | (s_axi_araddr == hpfs_pkg::REG_DRIVE)
	                  | (s_axi_araddr == hpfs_pkg::REG_SENSE);
	assign rd_val     = (s_axi_araddr == hpfs_pkg::REG_CTRL)  ? ctrl_r :
	                    (s_axi_araddr == hpfs_pkg::REG_DRIVE) ? drive_r :
	                    (s_axi_araddr == hpfs_pkg::REG_SENSE) ? {28'h0000000, sync2_r} : 32'h00000000;

	// Pin levels: address and read/write raw, strobes and select by polarity
	assign mux    = ctrl_r[hpfs_pkg::HB_MUX];
	assign dbl    = ctrl_r[hpfs_pkg::HB_DBL];
	assign ds_pol = ctrl_r[hpfs_pkg::HB_DS_POL];
	assign cs_pol = ctrl_r[hpfs_pkg::HB_CS_POL];
	assign pin_nxt[hpfs_pkg::PIN_A]  = drive_r[hpfs_pkg::PIN_A];
	assign pin_nxt[hpfs_pkg::PIN_RW] = dbl ? (drive_r[hpfs_pkg::PIN_RW] ~^ ds_pol)
	                                       : drive_r[hpfs_pkg::PIN_RW];
	assign pin_nxt[hpfs_pkg::PIN_DS] = drive_r[hpfs_pkg::PIN_DS] ~^ ds_pol;
	assign pin_nxt[hpfs_pkg::PIN_CS] = mux ? drive_r[hpfs_pkg::PIN_CS]
	                                       : (drive_r[hpfs_pkg::PIN_CS] ~^ cs_pol);

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= hpfs_pkg::RESP_OKAY;
			awaddr_r  <= 4'h0;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
			ctrl_r    <= 32'h00000000;
			drive_r   <= 32'h00000000;
		end else begin
			aw_got_r  <= aw_got_nxt;
			w_got_r   <= w_got_nxt;
			awready_r <= ~aw_got_nxt & ~do_wr & ~bvalid_nxt;
			wready_r  <= ~w_got_nxt & ~do_wr & ~bvalid_nxt;
			bvalid_r  <= bvalid_nxt;
			if (aw_hs) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_wr) begin
				bresp_r <= (wr_ctrl | wr_drive) ? hpfs_pkg::RESP_OKAY : hpfs_pkg::RESP_SLV;
			end
			if (wr_ctrl) begin
				ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & hpfs_pkg::HCTRL_MASK;
			end
			if (wr_drive) begin
				drive_r <= merge(drive_r, wdata_r, wstrb_r) & hpfs_pkg::DRIVE_MASK;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= hpfs_pkg::RESP_OKAY;
			sync1_r   <= 4'h0;
			sync2_r   <= 4'h0;
			host_o_r  <= 4'h0;
			host_oe_r <= 4'h0;
		end else begin
			arready_r <= ~rvalid_nxt & ~ar_hs;
			rvalid_r  <= rvalid_nxt;
			if (ar_hs) begin
				rdata_r <= rd_val;
				rresp_r <= rd_ok ? hpfs_pkg::RESP_OKAY : hpfs_pkg::RESP_SLV;
			end
			sync1_r   <= pins.pin_lvl;
			sync2_r   <= sync1_r;
			host_o_r  <= pin_nxt;
			host_oe_r <= ctrl_r[hpfs_pkg::HB_OE_LO +: hpfs_pkg::NPIN];
		end
	end

	assign pins.host_o   = host_o_r;
	assign pins.host_oe  = host_oe_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

endmodule : hpfs_host

// File: tb/hpfs_props.sv
/*
 * Assertions on the shared pins and device end of the host port pin select.
 * Assumes the bench instantiates it beside the interface, all on one aclk.
 */
`timescale 1ns/1ps
module hpfs_props (
	input wire logic                        aclk,
	input wire logic                        aresetn,
	input wire logic [hpfs_pkg::NPIN-1:0]   dev_o,
	input wire logic [hpfs_pkg::NPIN-1:0]   dev_oe,
	input wire logic [hpfs_pkg::NPIN-1:0]   pin_lvl,
	input wire logic                        cfg_we,
	input wire logic [hpfs_pkg::CTRL_W-1:0] cfg_wdata,
	input wire logic [2*hpfs_pkg::NPIN-1:0] pin_func,
	input wire logic                        a2,
	input wire logic                        a9,
	input wire logic                        a10,
	input wire logic                        rws,
	input wire logic                        rds,
	input wire logic                        sst,
	input wire logic                        wrs,
	input wire logic                        csi
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////////////
	logic [hpfs_pkg::CTRL_W-1:0] ctrl_r;
	logic [2:0]                  since_r;
	// Pin checks wait for the config path and the three-edge pin path to settle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r  <= hpfs_pkg::CTRL_RST;
			since_r <= 3'h0;
		end else if (cfg_we) begin
			ctrl_r  <= cfg_wdata;
			since_r <= 3'h0;
		end else if (since_r != 3'h7) begin
			since_r <= since_r + 3'h1;
		end
	end
	wire hi     = ctrl_r[hpfs_pkg::CB_HI_EN];
	wire mux    = ctrl_r[hpfs_pkg::CB_MUX];
	wire dbl    = ctrl_r[hpfs_pkg::CB_DBL];
	wire ds_inv = ~ctrl_r[hpfs_pkg::CB_DS_POL];
	wire cs_inv = ~ctrl_r[hpfs_pkg::CB_CS_POL];
	wire rdy    = hi && (since_r >= 3'h5);
	function automatic logic [7:0] func_of(input logic [hpfs_pkg::CTRL_W-1:0] w);
		logic [7:0] f;
		for (int i = 0; i < 4; i++) begin
			f[2*i +: 2] = (w[8+2*i +: 2] == 2'h3) ? 2'h0 : w[8+2*i +: 2];
		end
		return w[hpfs_pkg::CB_HI_EN] ? 8'hFF : f;
	endfunction : func_of
	sequence s_cfg_applied;
		cfg_we ##2 1'b1;
	endsequence
	////////////////////////////////////////////////////////////////////////////////////////
	chk_reset_quiet: assert property (!$past(aresetn) |->
		dev_oe == 4'h0 && pin_func == 8'h00)
		else $error("pins not disconnected after reset");
	chk_func_load: assert property (s_cfg_applied |->
		pin_func == func_of($past(cfg_wdata, 2)))
		else $error("pin function does not follow control word");
	chk_oe_follow: assert property (dev_oe == {
		pin_func[7] & ~pin_func[6], pin_func[5] & ~pin_func[4],
		pin_func[3] & ~pin_func[2], pin_func[1] & ~pin_func[0]})
		else $error("drive enable disagrees with pin function");
	chk_gpio_drive: assert property (s_cfg_applied |->
		(dev_o & dev_oe) == ($past(cfg_wdata[19:16], 2) & dev_oe))
		else $error("gpio output value wrong");
	chk_cs_qual: assert property (rdy && !mux |->
		csi == ($past(pin_lvl[3], 3) ^ cs_inv)
		&& a2 == $past(pin_lvl[0], 3) && !a9 && !a10)
		else $error("non-multiplexed select or address wrong");
	chk_addr_mux: assert property (rdy && mux |->
		a9 == $past(pin_lvl[0], 3)
		&& a10 == $past(pin_lvl[3], 3) && !csi && !a2)
		else $error("multiplexed address bits wrong");
	chk_dbl_strobe: assert property (rdy && dbl |->
		rds == ($past(pin_lvl[1], 3) ^ ds_inv)
		&& wrs == ($past(pin_lvl[2], 3) ^ ds_inv) && !sst && !rws)
		else $error("read or write strobe wrong");
	chk_sgl_strobe: assert property (rdy && !dbl |->
		rws == $past(pin_lvl[1], 3)
		&& sst == ($past(pin_lvl[2], 3) ^ ds_inv) && !rds && !wrs)
		else $error("data strobe or direction wrong");
	chk_gpio_isolate: assert property (!hi && since_r >= 3'h2 |->
		{a2, a9, a10, rws, rds, sst, wrs, csi} == 8'h00)
		else $error("host function active in gpio mode");
endmodule : hpfs_props

// File: tb/tb_host_port_pin_function_select.sv
/*
 * Bench for the host port pin function select: both ends joined by the interface.
 * Assumes package, interface, both ends and the checker are compiled first.
 */
`timescale 1ns/1ps
module tb_host_port_pin_function_select;
	logic        aclk = 1'b0, aresetn = 1'b0, cfg_we = 1'b0;
	logic [19:0] cfg_wdata = 20'h00000;
	logic [19:0] cfg_rdata;
	logic [7:0]  pin_func;
	logic [3:0]  gpio_in;
	logic        a2, a9, a10, rws, rds, sst, wrs, csi;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          err_total = 0, n_compared = 0;
	always #12.5 aclk = ~aclk;
	hpfs_if pins_if ();
	hpfs_dev hpfs_dev_inst (.aclk(aclk), .aresetn(aresetn), .pins(pins_if.dev), .cfg_we(cfg_we),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pin_func(pin_func), .gpio_in(gpio_in),
		.host_addr_bit_two(a2), .host_addr_bit_nine(a9), .host_addr_bit_ten(a10),
		.host_read_write_select(rws), .host_read_strobe(rds), .host_single_strobe(sst),
		.host_write_strobe(wrs), .host_chip_select_in(csi));
	hpfs_host hpfs_host_inst (.aclk(aclk), .aresetn(aresetn), .pins(pins_if.host),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	hpfs_props hpfs_props_inst (.aclk(aclk), .aresetn(aresetn), .dev_o(pins_if.dev_o),
		.dev_oe(pins_if.dev_oe), .pin_lvl(pins_if.pin_lvl), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
		.pin_func(pin_func), .a2(a2), .a9(a9), .a10(a10), .rws(rws), .rds(rds), .sst(sst),
		.wrs(wrs), .csi(csi));
	////////////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("compares %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	// Trailing edge in each task keeps a strobe from being driven twice in one step
	task automatic cfg(input logic [19:0] w);
		cfg_we    <= 1'b1;
		cfg_wdata <= w;
		@(posedge aclk);
		cfg_we <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask : cfg
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done  = 1'b0;
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd
	task automatic reset_chk();
		chk("pin_func", 8'h00, pin_func);
		chk("dev_oe", 4'h0, pins_if.dev_oe);
		chk("cfg_rdata", hpfs_pkg::CTRL_RST, cfg_rdata);
		chk("func outputs", 8'h00, {a2, a9, a10, rws, rds, sst, wrs, csi});
		chk("gpio_in", 4'h0, gpio_in);
		chk("pin_lvl", 4'hF, pins_if.pin_lvl);
	endtask : reset_chk
	////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(25 * 20000);
		err_total++;
		conclude();
	end
	initial begin
		logic [1:0]  rsp;
		logic [31:0] rd;
		logic [3:0]  d, pl;
		logic        mx, db, po;
		logic [7:0]  fx;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		reset_chk();
		axi_rd(4'hC, rd, rsp);
		chk("unmapped rresp", hpfs_pkg::RESP_SLV, rsp);
		axi_wr(4'hC, 32'h00000F0F, rsp);
		chk("unmapped bresp", hpfs_pkg::RESP_SLV, rsp);
		$display("test reset done");
		// Pin0 out at both levels, pin1 in, pin2 disc, pin3 mode 11; host drives pins 1 and 2
		axi_wr(hpfs_pkg::REG_CTRL, 32'h00000604, rsp);
		chk("ctrl bresp", hpfs_pkg::RESP_OKAY, rsp);
		for (int v = 0; v < 2; v++) begin
			cfg({3'h0, v[0], 16'hC600});
			axi_wr(hpfs_pkg::REG_DRIVE, v * 2, rsp);
			repeat (6) @(posedge aclk);
			chk("gpio pin_func", 8'h06, pin_func);
			chk("gpio_in", {2'h0, v[0], 1'b0}, gpio_in);
			axi_rd(hpfs_pkg::REG_SENSE, rd, rsp);
			chk("sense", {28'h0, 2'h2, v[0], v[0]}, rd);
		end
		$display("test gpio done");
		for (int m = 0; m < 8; m++) begin
			mx = m[0];
			db = m[1];
			po = m[2];
			cfg({15'h0000, po, po, db, mx, 1'b1});
			chk("cfg_rdata", {15'h0000, po, po, db, mx, 1'b1}, cfg_rdata);
			axi_wr(hpfs_pkg::REG_CTRL, {20'h0, 4'hF, 4'h0, po, po, db, mx}, rsp);
			for (int k = 0; k < 2; k++) begin
				d = k[0] ? 4'h5 : 4'hA;
				axi_wr(hpfs_pkg::REG_DRIVE, {28'h0, d}, rsp);
				repeat (6) @(posedge aclk);
				pl = {mx ? d[3] : d[3] ^ ~po, d[2] ^ ~po, db ? d[1] ^ ~po : d[1], d[0]};
				chk("pin_lvl", pl, pins_if.pin_lvl);
				chk("host pin_func", 8'hFF, pin_func);
				chk("host dev_oe", 4'h0, pins_if.dev_oe);
				fx = {~mx & d[0], mx & d[0], mx & d[3], ~db & d[1], db & d[1], ~db & d[2], db & d[2],
					~mx & d[3]};
				chk("addr outputs", fx[7:5], {a2, a9, a10});
				chk("single strobe", {fx[4], fx[2]}, {rws, sst});
				chk("double strobe", {fx[3], fx[1]}, {rds, wrs});
				chk("chip select", fx[0], csi);
			end
		end
		$display("test host modes done");
		// Reset in mid-run with the host function active
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		reset_chk();
		axi_rd(hpfs_pkg::REG_CTRL, rd, rsp);
		chk("host ctrl", 32'h00000000, rd);
		$display("test second reset done");
		conclude();
	end
endmodule : tb_host_port_pin_function_select
